// ==== pkg/shr_pkg.sv ====
// shared constants, register map and carrier types of the sensor register bank
`default_nettype none
package shr_pkg;
   // target address, upper six bits; the seventh comes from the address strap
   localparam logic [5:0] ADDR_BASE = 6'b10_0000;
   localparam logic [3:0] BYTE_BITS = 4'h8;        // bits per serial byte
   localparam logic [3:0] LAST_BIT = 4'h7;         // index of the last bit sent

   // register offsets
   localparam logic [7:0] OFS_TEMP_LOW = 8'h00;
   localparam logic [7:0] OFS_TEMP_HIGH = 8'h01;
   localparam logic [7:0] OFS_HUMID_LOW = 8'h02;
   localparam logic [7:0] OFS_HUMID_HIGH = 8'h03;
   localparam logic [7:0] OFS_EVENT_FLAGS = 8'h04;
   localparam logic [7:0] OFS_TEMP_PEAK = 8'h05;
   localparam logic [7:0] OFS_HUMID_PEAK = 8'h06;
   localparam logic [7:0] OFS_ALERT_ENABLES = 8'h07;
   localparam logic [7:0] OFS_TEMP_TRIM = 8'h08;
   localparam logic [7:0] OFS_HUMID_TRIM = 8'h09;
   localparam logic [7:0] OFS_TEMP_LIMIT_LOWER = 8'h0A;
   localparam logic [7:0] OFS_TEMP_LIMIT_UPPER = 8'h0B;
   localparam logic [7:0] OFS_HUMID_LIMIT_LOWER = 8'h0C;
   localparam logic [7:0] OFS_HUMID_LIMIT_UPPER = 8'h0D;
   localparam logic [7:0] OFS_DEVICE_SETUP = 8'h0E;
   localparam logic [7:0] OFS_CONVERSION_SETUP = 8'h0F;
   localparam logic [7:0] OFS_MAKER_CODE_LOW = 8'hFC;
   localparam logic [7:0] OFS_MAKER_CODE_HIGH = 8'hFD;
   localparam logic [7:0] OFS_PART_CODE_LOW = 8'hFE;
   localparam logic [7:0] OFS_PART_CODE_HIGH = 8'hFF;

   // reset values: zero and those that are not zero
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_TEMP_LIMIT_LOWER = 8'h01;
   localparam logic [7:0] RST_TEMP_LIMIT_UPPER = 8'hFF;
   localparam logic [7:0] RST_HUMID_LIMIT_UPPER = 8'hFF;

   // field positions
   localparam int FLAG_READY_BIT = 7;     // data-ready in event_flags
   localparam int FLAG_LIMIT_MSB = 6;     // four limit flags, bits 6..3
   localparam int FLAG_LIMIT_LSB = 3;
   localparam int SOFT_RESET_BIT = 7;     // self-clearing soft reset in device_setup

   // byte engine states
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
      ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
   } shr_state_t;

   // bus events from the pin watcher
   typedef struct packed {
      logic start;      // start or repeated start
      logic stop;       // stop condition
      logic scl_rise;   // clock rising edge
      logic scl_fall;   // clock falling edge
      logic sda;        // current data level
   } shr_edges_t;

   // pin watcher state
   typedef struct packed {
      logic scl;
      logic sda;
   } shr_pins_t;

   // finished conversion from the measurement engine
   typedef struct packed {
      logic done;               // one-cycle pulse, codes valid
      logic [15:0] temp;        // temperature code
      logic [15:0] humid;       // humidity code
      logic [3:0] limit_hit;    // limit events: temp upper, temp lower, humid upper, lower
   } shr_sample_t;

   // settings handed to the measurement engine
   typedef struct packed {
      logic [7:0] alert_enables;
      logic [7:0] temp_trim;
      logic [7:0] humid_trim;
      logic [7:0] temp_limit_lower;
      logic [7:0] temp_limit_upper;
      logic [7:0] humid_limit_lower;
      logic [7:0] humid_limit_upper;
      logic [7:0] device_setup;
      logic [7:0] conversion_setup;
   } shr_setup_t;

   // whole state of the register bank
   typedef struct packed {
      shr_state_t state;
      logic [3:0] cnt;          // bit counter within a byte
      logic [7:0] shift;        // receive shifter
      logic [7:0] tx;           // transmit shifter
      logic [7:0] ptr;          // register pointer
      logic rw;                 // direction of the current frame
      logic drive;              // pull data low
      logic acked;              // controller acknowledged the last byte
      logic [15:0][7:0] regs;   // offsets 0x00..0x0F
   } shr_core_t;
endpackage : shr_pkg
`default_nettype wire

// ==== hw/shr_bus_watch.sv ====
// watcher of the two serial pins: edges, start and stop
`timescale 1ns/1ps
`default_nettype none
module shr_bus_watch (
   input wire logic clk_i,                 // core clock
   input wire logic srst_i,                // synchronous reset, high
   input wire logic ce_i,                  // clock enable
   input wire logic scl_i,                 // serial clock level
   input wire logic sda_i,                 // serial data level
   output shr_pkg::shr_edges_t edges_o     // decoded bus events
);
   import shr_pkg::*;

   shr_pins_t st;        // previous pin levels
   shr_pins_t next_st;   // levels to remember

   // remember the pins each enabled cycle
   always_comb begin
      next_st.scl = scl_i;
      next_st.sda = sda_i;
   end

   // reset to the idle bus level, both lines high
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st <= '{scl: 1'b1, sda: 1'b1};
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   // data moving while clock stays high frames a transfer
   always_comb begin
      edges_o.start = ce_i & st.scl & scl_i & st.sda & ~sda_i;
      edges_o.stop = ce_i & st.scl & scl_i & ~st.sda & sda_i;
      edges_o.scl_rise = ce_i & ~st.scl & scl_i;
      edges_o.scl_fall = ce_i & st.scl & ~scl_i;
      edges_o.sda = sda_i;
   end
endmodule : shr_bus_watch
`default_nettype wire

// ==== hw/shr_regmap.sv ====
// serial target and register bank of the humidity and temperature sensor
`timescale 1ns/1ps
`default_nettype none
module shr_regmap #(
   parameter logic [7:0] MAKER_CODE_LOW = 8'h11,   // arbitrary value
   parameter logic [7:0] MAKER_CODE_HIGH = 8'h22,  // arbitrary value
   parameter logic [7:0] PART_CODE_LOW = 8'h33,    // arbitrary value
   parameter logic [7:0] PART_CODE_HIGH = 8'h44    // arbitrary value
) (
   input wire logic clk_i,                   // core clock, 20 MHz
   input wire logic srst_i,                  // synchronous reset, high
   input wire logic ce_i,                    // clock enable, freezes all state
   input wire logic addr_sel_i,              // address strap, lowest address bit
   input wire logic scl_i,                   // serial clock level
   input wire logic sda_i,                   // serial data level
   output logic sda_o,                       // data drive level, always low
   output logic sda_oe_o,                    // data pulled low while high
   input wire shr_pkg::shr_sample_t sample_i,   // conversion results
   output shr_pkg::shr_setup_t setup_o,      // writable settings
   output logic [7:0] event_flags_o          // live event flags
);
   import shr_pkg::*;

   shr_edges_t ed;       // bus events
   shr_core_t st;        // registered state
   shr_core_t next_st;   // next state

   // pin watcher
   shr_bus_watch u_watch (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .edges_o(ed)
   );

   // register contents after reset; limits open wide
   function automatic logic [15:0][7:0] regs_reset();
      logic [15:0][7:0] r;
      r = '0;
      r[OFS_TEMP_LIMIT_LOWER[3:0]] = RST_TEMP_LIMIT_LOWER;
      r[OFS_TEMP_LIMIT_UPPER[3:0]] = RST_TEMP_LIMIT_UPPER;
      r[OFS_HUMID_LIMIT_UPPER[3:0]] = RST_HUMID_LIMIT_UPPER;
      return r;
   endfunction : regs_reset

   // pointer values that name a register
   function automatic logic is_mapped(input logic [7:0] p);
      return (p <= OFS_CONVERSION_SETUP) || (p >= OFS_MAKER_CODE_LOW);
   endfunction : is_mapped

   // identification bytes refuse writes
   function automatic logic is_ident(input logic [7:0] p);
      return p >= OFS_MAKER_CODE_LOW;
   endfunction : is_ident

   // software-writable window
   function automatic logic is_writable(input logic [7:0] p);
      return (p >= OFS_ALERT_ENABLES) && (p <= OFS_CONVERSION_SETUP);
   endfunction : is_writable

   // read mux over bank and identification codes
   function automatic logic [7:0] read_reg(input shr_core_t c, input logic [7:0] p);
      logic [7:0] v;
      v = RST_ZERO;
      if (p <= OFS_CONVERSION_SETUP) begin
         v = c.regs[p[3:0]];
      end else if (p == OFS_MAKER_CODE_LOW) begin
         v = MAKER_CODE_LOW;
      end else if (p == OFS_MAKER_CODE_HIGH) begin
         v = MAKER_CODE_HIGH;
      end else if (p == OFS_PART_CODE_LOW) begin
         v = PART_CODE_LOW;
      end else if (p == OFS_PART_CODE_HIGH) begin
         v = PART_CODE_HIGH;
      end
      return v;
   endfunction : read_reg

   // fetch the byte at the pointer, drive its top bit, apply clear-on-read
   function automatic shr_core_t load_byte(input shr_core_t c);
      shr_core_t r;
      r = c;
      r.tx = read_reg(c, c.ptr);
      r.drive = ~r.tx[7];
      r.cnt = '0;
      r.state = ST_RD;
      // results and flags drop data-ready once read
      if (c.ptr <= OFS_EVENT_FLAGS) begin
         r.regs[OFS_EVENT_FLAGS[3:0]][FLAG_READY_BIT] = 1'b0;
      end
      // limit flags drop only when the flag byte itself is read
      if (c.ptr == OFS_EVENT_FLAGS) begin
         r.regs[OFS_EVENT_FLAGS[3:0]][FLAG_LIMIT_MSB:FLAG_LIMIT_LSB] = 4'h0;
      end
      return r;
   endfunction : load_byte

   // next state: bus protocol, then conversion events, then soft reset
   always_comb begin
      next_st = st;
      if (ed.start) begin
         // a restart keeps the pointer left by the last write or read
         next_st.state = ST_ADDR;
         next_st.cnt = '0;
         next_st.drive = 1'b0;
      end else if (ed.stop) begin
         // stop ends any frame and releases the line
         next_st.state = ST_IDLE;
         next_st.drive = 1'b0;
      end else begin
         case (st.state)
            ST_ADDR, ST_PTR, ST_WR: begin
               if (ed.scl_rise && (st.cnt < BYTE_BITS)) begin
                  // incoming bits enter at the bottom, first bit is the msb
                  next_st.shift = {st.shift[6:0], ed.sda};
                  next_st.cnt = st.cnt + 4'h1;
               end else if (ed.scl_fall && (st.cnt == BYTE_BITS)) begin
                  next_st.cnt = '0;
                  if (st.state == ST_ADDR) begin
                     // acknowledge only our own address
                     if (st.shift[7:1] == {ADDR_BASE, addr_sel_i}) begin
                        next_st.state = ST_ADDR_ACK;
                        next_st.rw = st.shift[0];
                        next_st.drive = 1'b1;
                     end else begin
                        next_st.state = ST_IDLE;
                     end
                  end else if (st.state == ST_PTR) begin
                     // pointer byte, refused when it names no register
                     if (is_mapped(st.shift)) begin
                        next_st.ptr = st.shift;
                        next_st.state = ST_PTR_ACK;
                        next_st.drive = 1'b1;
                     end else begin
                        next_st.state = ST_IDLE;
                     end
                  end else begin
                     // data byte: identification bytes are refused
                     next_st.state = ST_WR_ACK;
                     next_st.drive = ~is_ident(st.ptr);
                     if (is_writable(st.ptr)) begin
                        next_st.regs[st.ptr[3:0]] = st.shift;
                     end
                     next_st.ptr = st.ptr + 8'h01;
                  end
               end
            end
            ST_ADDR_ACK, ST_PTR_ACK, ST_WR_ACK: begin
               // ack bit ends on the falling clock
               if (ed.scl_fall) begin
                  next_st.drive = 1'b0;
                  if ((st.state == ST_ADDR_ACK) && st.rw) begin
                     next_st = load_byte(st);
                  end else if (st.state == ST_ADDR_ACK) begin
                     next_st.state = ST_PTR;
                  end else begin
                     next_st.state = ST_WR;
                  end
               end
            end
            ST_RD: begin
               // shift out on each falling clock, msb first
               if (ed.scl_fall) begin
                  if (st.cnt == LAST_BIT) begin
                     next_st.state = ST_RD_ACK;
                     next_st.drive = 1'b0;
                     next_st.acked = 1'b0;
                  end else begin
                     next_st.tx = {st.tx[6:0], 1'b0};
                     next_st.drive = ~st.tx[6];
                     next_st.cnt = st.cnt + 4'h1;
                  end
               end
            end
            ST_RD_ACK: begin
               if (ed.scl_rise) begin
                  // controller ack moves on, nack ends the read
                  if (!ed.sda) begin
                     next_st.acked = 1'b1;
                     next_st.ptr = st.ptr + 8'h01;
                  end else begin
                     next_st.state = ST_IDLE;
                  end
               end else if (ed.scl_fall && st.acked) begin
                  next_st = load_byte(st);
               end
            end
            default: begin
               next_st.state = ST_IDLE;
            end
         endcase
      end

      // a finished conversion lands both bytes of each code at once
      // codes arrive already scaled by the engine
      if (sample_i.done) begin
         next_st.regs[OFS_TEMP_LOW[3:0]] = sample_i.temp[7:0];
         next_st.regs[OFS_TEMP_HIGH[3:0]] = sample_i.temp[15:8];
         next_st.regs[OFS_HUMID_LOW[3:0]] = sample_i.humid[7:0];
         next_st.regs[OFS_HUMID_HIGH[3:0]] = sample_i.humid[15:8];
         // peaks track the high byte; only sound with one-shot triggering
         if (sample_i.temp[15:8] > st.regs[OFS_TEMP_PEAK[3:0]]) begin
            next_st.regs[OFS_TEMP_PEAK[3:0]] = sample_i.temp[15:8];
         end
         if (sample_i.humid[15:8] > st.regs[OFS_HUMID_PEAK[3:0]]) begin
            next_st.regs[OFS_HUMID_PEAK[3:0]] = sample_i.humid[15:8];
         end
         // set after the read clear, so a read in the same cycle never loses a new sample
         next_st.regs[OFS_EVENT_FLAGS[3:0]][FLAG_READY_BIT] = 1'b1;
      end
      // limit events stick until the flag byte is read
      next_st.regs[OFS_EVENT_FLAGS[3:0]][FLAG_LIMIT_MSB:FLAG_LIMIT_LSB] =
         next_st.regs[OFS_EVENT_FLAGS[3:0]][FLAG_LIMIT_MSB:FLAG_LIMIT_LSB] | sample_i.limit_hit;

      // soft reset one cycle after it is written; the bus frame goes on
      if (st.regs[OFS_DEVICE_SETUP[3:0]][SOFT_RESET_BIT]) begin
         next_st.regs = regs_reset();
      end
   end

   // one register for the whole state; ce low freezes it
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st <= '{state: ST_IDLE, cnt: 4'h0, shift: 8'h00, tx: 8'h00, ptr: 8'h00,
                 rw: 1'b0, drive: 1'b0, acked: 1'b0, regs: regs_reset()};
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   // open-drain data: only ever pulled low
   assign sda_o = 1'b0;
   assign sda_oe_o = st.drive;
   assign event_flags_o = st.regs[OFS_EVENT_FLAGS[3:0]];
   assign setup_o = '{
      alert_enables: st.regs[OFS_ALERT_ENABLES[3:0]],
      temp_trim: st.regs[OFS_TEMP_TRIM[3:0]],
      humid_trim: st.regs[OFS_HUMID_TRIM[3:0]],
      temp_limit_lower: st.regs[OFS_TEMP_LIMIT_LOWER[3:0]],
      temp_limit_upper: st.regs[OFS_TEMP_LIMIT_UPPER[3:0]],
      humid_limit_lower: st.regs[OFS_HUMID_LIMIT_LOWER[3:0]],
      humid_limit_upper: st.regs[OFS_HUMID_LIMIT_UPPER[3:0]],
      device_setup: st.regs[OFS_DEVICE_SETUP[3:0]],
      conversion_setup: st.regs[OFS_CONVERSION_SETUP[3:0]]
   };

   // checks on the byte engine and the bank
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   // a byte fully shifted in at the falling clock
   sequence byte_end_s;
      ce_i && ed.scl_fall && !ed.start && !ed.stop && (st.cnt == BYTE_BITS);
   endsequence

   // a fresh conversion with no soft reset pending
   sequence sample_s;
      ce_i && sample_i.done && !st.regs[OFS_DEVICE_SETUP[3:0]][SOFT_RESET_BIT];
   endsequence

   addr_ack_a: assert property ((st.state == ST_ADDR) && (st.shift[7:1] == {ADDR_BASE,
      addr_sel_i}) ##0 byte_end_s |=> sda_oe_o && (st.state == ST_ADDR_ACK))
      else $error("own address not acknowledged");
   ptr_load_a: assert property ((st.state == ST_PTR) && is_mapped(st.shift) ##0 byte_end_s
      |=> (st.ptr == $past(st.shift)) && sda_oe_o)
      else $error("pointer byte not loaded");
   ptr_unused_a: assert property ((st.state == ST_PTR) && !is_mapped(st.shift) ##0 byte_end_s
      |=> !sda_oe_o && (st.state == ST_IDLE))
      else $error("unused pointer acknowledged");
   ident_nack_a: assert property ((st.state == ST_WR) && is_ident(st.ptr) ##0 byte_end_s
      |=> !sda_oe_o && (st.state == ST_WR_ACK))
      else $error("identification write acknowledged");
   ptr_step_a: assert property ((st.state == ST_WR) ##0 byte_end_s
      |=> st.ptr == $past(st.ptr) + 8'h01)
      else $error("pointer did not advance after write");
   msb_first_a: assert property (ce_i && ed.scl_fall && !ed.start && !ed.stop && st.rw &&
      (st.state == ST_ADDR_ACK) |=> (sda_oe_o == ($past(read_reg(st, st.ptr)) < 8'h80))
      && (st.state == ST_RD))
      else $error("read byte does not open with its msb");
   read_nack_a: assert property (ce_i && ed.scl_rise && ed.sda && !ed.start && !ed.stop &&
      (st.state == ST_RD_ACK) |=> (st.state == ST_IDLE) && !sda_oe_o)
      else $error("read did not end on nack");
   result_pair_a: assert property (sample_s |=> (st.regs[0] == $past(sample_i.temp[7:0])) &&
      (st.regs[1] == $past(sample_i.temp[15:8])) && (st.regs[3] == $past(sample_i.humid[15:8])))
      else $error("result bytes not updated together");
   ready_set_a: assert property (sample_s |=> event_flags_o[FLAG_READY_BIT])
      else $error("data-ready not raised by a conversion");
   peak_hold_a: assert property (sample_s ##0 (sample_i.temp[15:8] > st.regs[5])
      |=> st.regs[5] == $past(sample_i.temp[15:8]))
      else $error("temperature peak not raised");
   soft_reset_a: assert property (ce_i && st.regs[OFS_DEVICE_SETUP[3:0]][SOFT_RESET_BIT]
      |=> (setup_o.device_setup == RST_ZERO) && (st.regs[0] == RST_ZERO))
      else $error("soft reset did not clear the bank");
endmodule : shr_regmap
`default_nettype wire

// ==== tb/shr_ctl_model.sv ====
// serial bus controller model that drives the register bank's pins
`timescale 1ns/1ps
`default_nettype none
module shr_ctl_model (
   input wire logic clk_i, // core clock, paces the bus
   input wire logic sda_i, // resolved data wire
   output logic scl_o, // serial clock, idle high
   output logic sda_oe_o // pulls data low while high
);
   // idle bus: both lines released to the pull-ups
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   // whole clocks, always moving just after the falling edge
   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask : tick
   // start or repeated start: data falls while clock is high
   task automatic start();
      sda_oe_o = 1'b0;
      tick(2);
      scl_o = 1'b1;
      tick(4);
      sda_oe_o = 1'b1;
      tick(4);
      scl_o = 1'b0;
      tick(2);
   endtask : start
   // stop: data rises while clock is high, ends every frame
   task automatic stop();
      sda_oe_o = 1'b1;
      tick(2);
      scl_o = 1'b1;
      tick(4);
      sda_oe_o = 1'b0;
      tick(4);
   endtask : stop
   // one bit: data moves only in the low phase, sampled late in the high phase
   task automatic bit_x(input logic b, output logic r);
      tick(1);
      sda_oe_o = ~b;
      tick(3);
      scl_o = 1'b1;
      tick(3);
      r = sda_i;
      tick(1);
      scl_o = 1'b0;
   endtask : bit_x
   // byte msb first, then the ninth bit; a read passes ff to stay off the wire
   task automatic xfer(input logic [7:0] d, input logic ack_bit, output logic [7:0] q,
                       output logic ack_seen);
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(ack_bit, ack_seen); // last read byte gets nack
   endtask : xfer
endmodule : shr_ctl_model
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench of the sensor register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   import shr_pkg::*;
   logic clk_i, srst_i, scl, ctl_oe, dut_oe, dut_sda, sda, a, ce; // clock, reset, wires, enable
   logic [7:0] q, flags; // last received byte, live flags
   logic [7:0] wv[16], exp_b[16]; // bytes to write, bytes expected back
   shr_sample_t sample; // conversion results fed in
   shr_setup_t setup; // settings seen at the outputs
   int num_errors = 0;
   int n_checks = 0;
   assign sda = (dut_oe ? dut_sda : 1'b1) & ~ctl_oe; // open drain with pull-up
   shr_regmap DUT (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce), .addr_sel_i(1'b1),
      .scl_i(scl), .sda_i(sda), .sda_o(dut_sda), .sda_oe_o(dut_oe), .sample_i(sample),
      .setup_o(setup), .event_flags_o(flags));
   shr_ctl_model ctl (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(ctl_oe));
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done();
      if (num_errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   // address with write direction, then the pointer byte
   task automatic point(input logic [7:0] p, input logic nack);
      ctl.start();
      ctl.xfer({ADDR_BASE, 1'b1, 1'b0}, 1'b1, q, a);
      check({7'h0, a}, 8'h00);
      ctl.xfer(p, 1'b1, q, a);
      check({7'h0, a}, {7'h0, nack});
   endtask : point
   // n bytes from wv, each ninth bit compared with nack
   task automatic wr_run(input logic [7:0] p, input int n, input logic nack);
      point(p, 1'b0);
      for (int i = 0; i < n; i++) begin
         ctl.xfer(wv[i], 1'b1, q, a);
         check({7'h0, a}, {7'h0, nack});
      end
      ctl.stop();
   endtask : wr_run
   // n bytes against exp_b; without a pointer write the old pointer is used
   task automatic rd_run(input logic [7:0] p, input int n, input logic new_ptr);
      if (new_ptr) point(p, 1'b0);
      ctl.start();
      ctl.xfer({ADDR_BASE, 1'b1, 1'b1}, 1'b1, q, a);
      check({7'h0, a}, 8'h00);
      for (int i = 0; i < n; i++) begin
         ctl.xfer(8'hFF, i == n - 1, q, a);
         check(q, exp_b[i]);
      end
      ctl.stop();
   endtask : rd_run
   // whole low bank straight after reset
   task automatic s_reset();
      exp_b = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                8'h01, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00};
      rd_run(8'h00, 16, 1'b1);
   endtask : s_reset
   // burst write of the settings, ignored write to a result byte
   task automatic s_write();
      wv = '{8'h55, 8'h66, 8'h77, 8'h88, 8'h99, 8'hAA, 8'hBB, 8'h7F, 8'hC3, 8'h00,
             8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      wr_run(8'h07, 9, 1'b0);
      exp_b = wv;
      rd_run(8'h07, 9, 1'b1);
      check(setup.alert_enables, 8'h55);
      wv[0] = 8'hA5;
      wr_run(8'h00, 1, 1'b0);
      exp_b[0] = 8'h00;
      rd_run(8'h00, 1, 1'b1);
   endtask : s_write
   // a conversion lands in both bytes at once, peaks and flags follow
   task automatic s_sample();
      // a conversion offered while the enable is low must leave the bank untouched
      @(negedge clk_i);
      ce = 1'b0;
      sample = '{done: 1'b1, temp: 16'h0F0F, humid: 16'h0F0F, limit_hit: 4'hF};
      @(negedge clk_i);
      sample = '0;
      ce = 1'b1;
      @(negedge clk_i);
      check(flags, 8'h00);
      @(negedge clk_i);
      sample = '{done: 1'b1, temp: 16'hBEEF, humid: 16'h1234, limit_hit: 4'hA};
      @(negedge clk_i);
      sample = '0;
      @(negedge clk_i);
      check(flags, 8'hD0);
      exp_b[0:6] = '{8'hEF, 8'hBE, 8'h34, 8'h12, 8'h50, 8'hBE, 8'h12};
      rd_run(8'h00, 7, 1'b1);
      exp_b[0] = 8'h00;
      rd_run(8'h04, 1, 1'b1);
      rd_run(8'h00, 1, 1'b0);
   endtask : s_sample
   // wrong address, unused pointer, writes to the identification bytes
   task automatic s_refuse();
      ctl.start();
      ctl.xfer({ADDR_BASE, 1'b0, 1'b0}, 1'b1, q, a);
      check({7'h0, a}, 8'h01);
      ctl.stop();
      point(8'h20, 1'b1);
      ctl.stop();
      wr_run(8'hFC, 2, 1'b1);
      exp_b[0:3] = '{8'h11, 8'h22, 8'h33, 8'h44};
      rd_run(8'hFC, 4, 1'b1);
   endtask : s_refuse
   // soft reset returns the settings to their reset values
   task automatic s_soft();
      wv[0] = 8'h80;
      wr_run(8'h0E, 1, 1'b0);
      exp_b[0:8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00};
      rd_run(8'h07, 9, 1'b1);
   endtask : s_soft
   // whole run is some 7200 clocks; the limit leaves ample margin
   initial begin
      repeat (40000) @(posedge clk_i);
      num_errors++;
      test_done();
   end
   // reset with the bus idle, then the scenarios in turn
   initial begin
      srst_i = 1'b1;
      ce = 1'b1;
      sample = '0;
      repeat (16) @(negedge clk_i);
      srst_i = 1'b0;
      s_reset();
      s_write();
      s_sample();
      s_refuse();
      s_soft();
      test_done();
   end
endmodule : tb
`default_nettype wire
